/* File: core/mmd_pkg.sv */
// Constants and types shared by the memory map decoder and its boot word store
`default_nettype none
package mmd_pkg;
  localparam int BLK_HI   = 31;
  localparam int BLK_LO   = 28;
  localparam int HALF_BIT = 27;
  localparam logic [3:0] BLK_EXT0 = 4'h0;
  localparam logic [3:0] BLK_EXT1 = 4'h1;
  localparam logic [3:0] BLK_SMEM = 4'h4;
  localparam logic [3:0] BLK_DSP  = 4'h5;
  localparam logic [3:0] BLK_USBV = 4'h7;
  localparam logic [3:0] BLK_APB  = 4'h8;
  localparam logic [3:0] BLK_LCD  = 4'h9;
  localparam logic [3:0] BLK_TCM  = 4'ha;
  localparam logic [31:0] ROM_BASE   = 32'h4800_0000;
  localparam logic [31:0] BOOT_WORD0 = 32'he51f_f004;
  localparam logic [31:0] BOOT_WORD1 = ROM_BASE;
  localparam int BOOT_IDX_HI = 26;
  localparam int BOOT_IDX_LO = 3;
  localparam int WORD_SEL    = 2;
  localparam int EXT_A_HI = 25;
  localparam int EXT_A_LO = 1;
  localparam int EXT_AW   = EXT_A_HI - EXT_A_LO + 1;
  localparam int EXT_DW   = 16;
  localparam int NUM_CS   = 3;
  localparam logic [1:0] CS_BANK0 = 2'h0;
  localparam logic [1:0] CS_BANK1 = 2'h1;
  localparam logic [1:0] CS_BANK2 = 2'h2;
  localparam int PADDR_W  = 16;
  localparam int SLOT_HI  = 23;
  localparam int SLOT_LO  = 16;
  localparam int WAIT_W   = 4;
  localparam int CNT_W    = WAIT_W + 1;
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int HTRANS_ACT = 1;
  localparam logic BOOT_MAP_ON = 1'b0;
  localparam int NUM_SEL = 7;
  localparam int SEL_RAM = 0;
  localparam int SEL_ROM = 1;
  localparam int SEL_DSP = 2;
  localparam int SEL_USB = 3;
  localparam int SEL_VFF = 4;
  localparam int SEL_LCD = 5;
  localparam int SEL_TCM = 6;
  typedef enum logic [3:0] {
    TGT_NONE, TGT_EXT, TGT_BOOT, TGT_RAM, TGT_ROM, TGT_DSP,
    TGT_USB, TGT_VFF, TGT_APB, TGT_LCD, TGT_TCM
  } mmd_tgt_e;
  typedef enum logic [2:0] {
    ST_IDLE, ST_EXT, ST_APB_SETUP, ST_APB_ACCESS, ST_DONE
  } mmd_state_e;
endpackage
`default_nettype wire

/* File: core/mmd_boot_rom.sv */
// Two-word boot store with registered read data
`default_nettype none
module mmd_boot_rom
  import mmd_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        rd_en_in,
  input  wire logic        word_sel_in,
  input  wire logic        beyond_in,
  output logic [31:0]      data_out
);
  logic [31:0] data_r;

  // Words past the second read as zero rather than aliasing
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_r <= 32'h0000_0000;
    end else if (rd_en_in) begin
      if (beyond_in) begin
        data_r <= 32'h0000_0000;
      end else begin
        data_r <= word_sel_in ? BOOT_WORD1 : BOOT_WORD0;
      end
    end
  end

  assign data_out = data_r;
endmodule
`default_nettype wire

/* File: core/mmd_decoder.sv */
// Central address decoder with external splitter, APB bridge and boot remap
`default_nettype none
module mmd_decoder
  import mmd_pkg::*;
(
  input  wire logic                 sys_clk_in,
  input  wire logic                 sys_rst_in,
  input  wire logic [31:0]          haddr_in,
  input  wire logic [1:0]           htrans_in,
  input  wire logic                 hwrite_in,
  input  wire logic [2:0]           hsize_in,
  input  wire logic [31:0]          hwdata_in,
  input  wire logic                 hready_in,
  output logic [NUM_SEL-1:0]        hsel_out,
  output logic                      hreadyout_out,
  output logic [31:0]               hrdata_out,
  input  wire logic                 bank_swap_bit_in,
  input  wire logic                 boot_map_bit_in,
  input  wire logic [WAIT_W-1:0]    ext_wait_cycles_in,
  output logic [EXT_A_HI:EXT_A_LO]  ext_addr_out,
  output logic [NUM_CS-1:0]         ext_cs_n_out,
  output logic                      ext_oe_n_out,
  output logic                      ext_we_n_out,
  output logic [1:0]                ext_be_n_out,
  output logic [EXT_DW-1:0]         ext_dout_out,
  output logic                      ext_dout_en_out,
  input  wire logic [EXT_DW-1:0]    ext_din_in,
  output logic                      apb_clk_en_out,
  output logic                      psel_out,
  output logic                      penable_out,
  output logic                      pwrite_out,
  output logic [PADDR_W-1:0]        paddr_out,
  output logic [SLOT_HI-SLOT_LO:0]  apb_slot_out,
  output logic [31:0]               pwdata_out,
  input  wire logic [31:0]          prdata_in,
  input  wire logic                 pready_in,
  input  wire logic                 apb_wide_in
);

  function automatic mmd_tgt_e decode(input logic [31:0] a, input logic boot_on);
    logic hi;
    hi = a[HALF_BIT];
    case (a[BLK_HI:BLK_LO])
      BLK_EXT0: decode = (!hi && boot_on) ? TGT_BOOT : TGT_EXT;
      BLK_EXT1: decode = hi ? TGT_NONE : TGT_EXT;
      BLK_SMEM: decode = hi ? TGT_ROM : TGT_RAM;
      BLK_DSP:  decode = TGT_DSP;
      BLK_USBV: decode = hi ? TGT_VFF : TGT_USB;
      BLK_APB:  decode = TGT_APB;
      BLK_LCD:  decode = hi ? TGT_NONE : TGT_LCD;
      BLK_TCM:  decode = TGT_TCM;
      default:  decode = TGT_NONE;
    endcase
  endfunction

  function automatic logic [NUM_CS-1:0] cs_onehot(input logic [31:0] a,
                                                  input logic swap);
    logic [1:0] idx;
    idx = (a[BLK_HI:BLK_LO] == BLK_EXT1) ? CS_BANK2
        : (a[HALF_BIT] ? CS_BANK1 : CS_BANK0);
    if (swap && idx != CS_BANK2) begin
      idx = (idx == CS_BANK0) ? CS_BANK1 : CS_BANK0;
    end
    cs_onehot = '0;
    cs_onehot[idx] = 1'b1;
  endfunction

  mmd_state_e                state_r;
  mmd_tgt_e                  tgt_r;
  mmd_tgt_e                  tgt_nxt;
  logic                      boot_on;
  logic                      take;
  logic                      write_r;
  logic                      lane_r;
  logic                      half_r;
  logic                      halves_r;
  logic                      hi_lane;
  logic                      cyc_last;
  logic [CNT_W-1:0]          cnt_r;
  logic [31:0]               rdata_r;
  logic [31:0]               rom_q;
  logic [EXT_A_HI:EXT_A_LO]  ext_addr_r;
  logic [NUM_CS-1:0]         ext_cs_n_r;
  logic                      ext_oe_n_r;
  logic                      ext_we_n_r;
  logic [1:0]                ext_be_n_r;
  logic [EXT_DW-1:0]         ext_dout_r;
  logic                      psel_r;
  logic                      penable_r;
  logic                      pwrite_r;
  logic [PADDR_W-1:0]        paddr_r;
  logic [SLOT_HI-SLOT_LO:0]  slot_r;
  logic [31:0]               pwdata_r;

  // Boot words present from reset so the very first fetch finds them
  assign boot_on = (boot_map_bit_in == BOOT_MAP_ON);
  // Arbitration happens upstream; only an owned, active, ready phase counts
  assign take    = hready_in && htrans_in[HTRANS_ACT];
  assign tgt_nxt = decode(haddr_in, boot_on);
  assign hi_lane = half_r | lane_r;
  assign cyc_last = (cnt_r == ({1'b0, ext_wait_cycles_in} + 5'h1));

  // Address-phase selects for slaves that answer on AHB themselves
  always_comb begin
    hsel_out = '0;
    case (tgt_nxt)
      TGT_RAM: hsel_out[SEL_RAM] = 1'b1;
      TGT_ROM: hsel_out[SEL_ROM] = 1'b1;
      TGT_DSP: hsel_out[SEL_DSP] = 1'b1;
      TGT_USB: hsel_out[SEL_USB] = 1'b1;
      TGT_VFF: hsel_out[SEL_VFF] = 1'b1;
      TGT_LCD: hsel_out[SEL_LCD] = 1'b1;
      TGT_TCM: hsel_out[SEL_TCM] = 1'b1;
      default: hsel_out = '0;
    endcase
  end

  mmd_boot_rom u_boot_rom (
    .clk_in      (sys_clk_in),
    .rst_in      (sys_rst_in),
    .rd_en_in    (take && tgt_nxt == TGT_BOOT && !hwrite_in),
    .word_sel_in (haddr_in[WORD_SEL]),
    .beyond_in   (haddr_in[BOOT_IDX_HI:BOOT_IDX_LO] != '0),
    .data_out    (rom_q)
  );

  // Sequencer and data-phase bookkeeping
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_r  <= ST_IDLE;
      tgt_r    <= TGT_NONE;
      write_r  <= 1'b0;
      lane_r   <= 1'b0;
      half_r   <= 1'b0;
      halves_r <= 1'b0;
      cnt_r    <= '0;
    end else begin
      case (state_r)
        ST_IDLE, ST_DONE: begin
          state_r <= ST_IDLE;
          if (take) begin
            tgt_r    <= tgt_nxt;
            write_r  <= hwrite_in;
            lane_r   <= haddr_in[EXT_A_LO];
            half_r   <= 1'b0;
            halves_r <= (hsize_in == HSIZE_WORD);
            cnt_r    <= '0;
            if (tgt_nxt == TGT_EXT) begin
              state_r <= ST_EXT;
            end else if (tgt_nxt == TGT_APB) begin
              state_r <= ST_APB_SETUP;
            end
          end else begin
            tgt_r <= TGT_NONE;
          end
        end
        ST_EXT: begin
          if (cyc_last) begin
            cnt_r <= '0;
            if (half_r == halves_r) begin
              state_r <= ST_DONE;
            end else begin
              half_r <= 1'b1;
            end
          end else begin
            cnt_r <= cnt_r + 5'h1;
          end
        end
        ST_APB_SETUP: state_r <= ST_APB_ACCESS;
        ST_APB_ACCESS: begin
          if (pready_in) begin
            state_r <= ST_DONE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // External pins; strobes fall one cycle after the select, wait states stretch them
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ext_addr_r <= '0;
      ext_cs_n_r <= '1;
      ext_oe_n_r <= 1'b1;
      ext_we_n_r <= 1'b1;
      ext_be_n_r <= '1;
      ext_dout_r <= '0;
    end else if ((state_r == ST_IDLE || state_r == ST_DONE) && take
                 && tgt_nxt == TGT_EXT) begin
      ext_addr_r <= haddr_in[EXT_A_HI:EXT_A_LO];
      ext_cs_n_r <= ~cs_onehot(haddr_in, bank_swap_bit_in);
      if (hsize_in == HSIZE_BYTE) begin
        ext_be_n_r <= haddr_in[0] ? 2'h1 : 2'h2;
      end else begin
        ext_be_n_r <= 2'h0;
      end
    end else if (state_r == ST_EXT) begin
      ext_dout_r <= hi_lane ? hwdata_in[31:16] : hwdata_in[15:0];
      if (cyc_last) begin
        ext_oe_n_r <= 1'b1;
        ext_we_n_r <= 1'b1;
        if (half_r == halves_r) begin
          ext_cs_n_r <= '1;
        end else begin
          ext_addr_r <= ext_addr_r + 25'h1;
        end
      end else begin
        ext_oe_n_r <= write_r;
        ext_we_n_r <= !write_r;
      end
    end
  end

  // Read data gathered lane by lane, little endian
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_r <= '0;
    end else if ((state_r == ST_IDLE || state_r == ST_DONE) && take) begin
      rdata_r <= '0;
    end else if (state_r == ST_EXT && cyc_last && !write_r) begin
      if (hi_lane) begin
        rdata_r[31:16] <= ext_din_in;
      end else begin
        rdata_r[15:0] <= ext_din_in;
      end
    end else if (state_r == ST_APB_ACCESS && pready_in && !pwrite_r) begin
      rdata_r <= apb_wide_in ? prdata_in : {16'h0000, prdata_in[15:0]};
    end
  end

  // APB bridge side; offsets only, the slot picks the peripheral
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      psel_r    <= 1'b0;
      penable_r <= 1'b0;
      pwrite_r  <= 1'b0;
      paddr_r   <= '0;
      slot_r    <= '0;
      pwdata_r  <= '0;
    end else begin
      case (state_r)
        ST_IDLE, ST_DONE: begin
          if (take && tgt_nxt == TGT_APB) begin
            psel_r   <= 1'b1;
            pwrite_r <= hwrite_in;
            paddr_r  <= haddr_in[PADDR_W-1:0];
            slot_r   <= haddr_in[SLOT_HI:SLOT_LO];
          end
        end
        ST_APB_SETUP: begin
          penable_r <= 1'b1;
          pwdata_r  <= apb_wide_in ? hwdata_in : {16'h0000, hwdata_in[15:0]};
        end
        ST_APB_ACCESS: begin
          if (pready_in) begin
            psel_r    <= 1'b0;
            penable_r <= 1'b0;
          end
        end
        default: begin
          psel_r    <= 1'b0;
          penable_r <= 1'b0;
        end
      endcase
    end
  end

  assign hreadyout_out   = (state_r == ST_IDLE || state_r == ST_DONE);
  assign hrdata_out      = (tgt_r == TGT_BOOT) ? rom_q : rdata_r;
  assign ext_addr_out    = ext_addr_r;
  assign ext_cs_n_out    = ext_cs_n_r;
  assign ext_oe_n_out    = ext_oe_n_r;
  assign ext_we_n_out    = ext_we_n_r;
  assign ext_be_n_out    = ext_be_n_r;
  assign ext_dout_out    = ext_dout_r;
  assign ext_dout_en_out = !ext_we_n_r;
  // Gated clock enable follows the select so it spans setup and access
  assign apb_clk_en_out  = psel_r;
  assign psel_out        = psel_r;
  assign penable_out     = penable_r;
  assign pwrite_out      = pwrite_r;
  assign paddr_out       = paddr_r;
  assign apb_slot_out    = slot_r;
  assign pwdata_out      = pwdata_r;

  logic [CNT_W-1:0] lo_cnt_r;
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      lo_cnt_r <= '0;
    end else if (ext_oe_n_r && ext_we_n_r) begin
      lo_cnt_r <= '0;
    end else begin
      lo_cnt_r <= lo_cnt_r + 5'h1;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  blk_ram_sel_a: assert property (
    take && haddr_in[31:27] == 5'h08 |-> hsel_out == 7'h01)
    else $error("RAM half-block not selected");
  boot_no_ext_a: assert property (
    hreadyout_out && take && tgt_nxt == TGT_BOOT |=> ext_cs_n_out == 3'h7 && hreadyout_out)
    else $error("Boot read touched external bus");
  boot_word0_a: assert property (
    hreadyout_out && take && tgt_nxt == TGT_BOOT && !hwrite_in
    && haddr_in[26:2] == '0 |=> hrdata_out == BOOT_WORD0)
    else $error("Boot word zero wrong");
  swap_cs_a: assert property (
    hreadyout_out && take && haddr_in[31:27] == 5'h01 && bank_swap_bit_in
    |=> ext_cs_n_out == 3'h6)
    else $error("Bank swap did not move select");
  ext_split_a: assert property (
    state_r == ST_EXT && cyc_last && !half_r && halves_r
    |=> state_r == ST_EXT && ext_addr_out == $past(ext_addr_out) + 25'h1)
    else $error("Word not split into two halfword cycles");
  wait_len_a: assert property (
    $rose(ext_oe_n_out & ext_we_n_out) |-> $past(lo_cnt_r) == $past(ext_wait_cycles_in))
    else $error("Strobe length differs from wait setting");
  apb_seq_a: assert property (
    hreadyout_out && take && tgt_nxt == TGT_APB
    |=> psel_out && !penable_out ##1 psel_out && penable_out)
    else $error("APB setup/access order broken");
  apb_clk_a: assert property (
    hreadyout_out && !psel_out |=> !apb_clk_en_out || $past(take))
    else $error("APB clock ran while idle");
  apb_narrow_a: assert property (
    state_r == ST_APB_ACCESS && pready_in && !pwrite_out && !apb_wide_in
    |=> hrdata_out[31:16] == 16'h0000)
    else $error("Narrow peripheral upper half not zero");
  rsv_quiet_a: assert property (
    hreadyout_out && take && tgt_nxt == TGT_NONE
    |-> hsel_out == '0 ##1 hreadyout_out && !psel_out && ext_cs_n_out == 3'h7)
    else $error("Reserved access not completed quietly");
  byte_lane_a: assert property (
    hreadyout_out && take && tgt_nxt == TGT_EXT && hsize_in == HSIZE_BYTE
    |=> ext_be_n_out[0] == $past(haddr_in[0]) && ext_be_n_out[1] != $past(haddr_in[0]))
    else $error("Byte lane enable wrong");

  cov_ext_word_c: cover property (state_r == ST_EXT && half_r && cyc_last);
  cov_apb_c: cover property (state_r == ST_APB_ACCESS && pready_in);
  cov_boot_c: cover property (take && tgt_nxt == TGT_BOOT);
  cov_rsv_c: cover property (take && tgt_nxt == TGT_NONE);
endmodule
`default_nettype wire

/* File: test/mmd_far_model.sv */
// Far side model: 16-bit external memory and one APB slave
`default_nettype none
module mmd_far_model
  import mmd_pkg::*;
(
  input  wire logic                     clk_in,
  input  wire logic                     rst_in,
  input  wire logic [EXT_A_HI:EXT_A_LO] ea_in,
  input  wire logic [NUM_CS-1:0]        cs_n_in,
  input  wire logic                     oe_n_in,
  input  wire logic                     we_n_in,
  input  wire logic [1:0]               be_n_in,
  input  wire logic [EXT_DW-1:0]        dout_in,
  output logic [EXT_DW-1:0]             din_out,
  input  wire logic                     psel_in,
  input  wire logic                     pen_in,
  input  wire logic [PADDR_W-1:0]       paddr_in,
  input  wire logic [7:0]               slot_in,
  input  wire logic [31:0]              pwdata_in,
  input  wire logic [1:0]               dly_in,
  output logic [31:0]                   prdata_out,
  output logic                          pready_out,
  output logic [NUM_CS-1:0]             cs_seen_out,
  output logic [31:0]                   wd_seen_out,
  output logic [7:0]                    slot_seen_out,
  output logic [15:0]                   strb_cnt_out
);
  logic [15:0] mem_r [16];
  logic [15:0] junk_r;
  logic [1:0]  dly_r;
  logic        sel;
  assign sel = (cs_n_in != 3'h7);
  // Released lines toggle so stale data never passes for a match
  assign din_out = (sel && !oe_n_in) ? mem_r[ea_in[4:1]] : junk_r;
  assign prdata_out = (psel_in && pen_in) ? {~paddr_in, paddr_in} : {junk_r, ~junk_r};
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < 16; i++) begin
        mem_r[i] <= {i[3:0], 12'h5a3};
      end
      junk_r <= 16'h3c96;
      dly_r <= 2'h0;
      pready_out <= 1'b0;
      strb_cnt_out <= 16'h0;
      cs_seen_out <= 3'h7;
      wd_seen_out <= 32'h0;
      slot_seen_out <= 8'h0;
    end else begin
      junk_r <= ~junk_r;
      if (sel && !we_n_in && !be_n_in[0]) mem_r[ea_in[4:1]][7:0] <= dout_in[7:0];
      if (sel && !we_n_in && !be_n_in[1]) mem_r[ea_in[4:1]][15:8] <= dout_in[15:8];
      if (sel && !(oe_n_in && we_n_in)) begin
        strb_cnt_out <= strb_cnt_out + 16'h1;
        cs_seen_out <= cs_n_in;
      end
      // Access phase stalls for dly_in plus one cycles before the answer
      if (pready_out) begin
        pready_out <= 1'b0;
        wd_seen_out <= pwdata_in;
        slot_seen_out <= slot_in;
      end else if (psel_in && pen_in && dly_r == 2'h0) begin
        pready_out <= 1'b1;
      end else if (psel_in && pen_in) begin
        dly_r <= dly_r - 2'h1;
      end else begin
        dly_r <= dly_in;
      end
    end
  end
endmodule
`default_nettype wire

/* File: test/mmd_decoder_test.sv */
// Random and directed bench for the memory map decoder
`default_nettype none
module mmd_decoder_test
  import mmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     clk, rst, hwrite, hready, hrdy, swap, bmap, wide;
  logic                     oe_n, we_n, apb_en, psel, pen, pready, pwr, den;
  logic [31:0]              haddr, hwdata, hrdata, pwdata, prdata, wseen, seed;
  logic [1:0]               htrans, be_n, dly;
  logic [2:0]               hsize, cs_n, cs_seen;
  logic [WAIT_W-1:0]        wt;
  logic [NUM_SEL-1:0]       hsel, sel_seen;
  logic [EXT_A_HI:EXT_A_LO] eaddr;
  logic [15:0]              dout, din, paddr, scnt;
  logic [7:0]               slot, slot_seen;
  logic [15:0]              shadow [16];
  logic [31:0]              bases [8];
  logic [31:0]              corner [14];
  int                       err_total, checked, apb_on;

  mmd_decoder mmd_decoder_i (
    .sys_clk_in(clk), .sys_rst_in(rst), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
    .hsel_out(hsel), .hreadyout_out(hrdy), .hrdata_out(hrdata),
    .bank_swap_bit_in(swap), .boot_map_bit_in(bmap), .ext_wait_cycles_in(wt),
    .ext_addr_out(eaddr), .ext_cs_n_out(cs_n), .ext_oe_n_out(oe_n), .ext_we_n_out(we_n),
    .ext_be_n_out(be_n), .ext_dout_out(dout), .ext_dout_en_out(den), .ext_din_in(din),
    .apb_clk_en_out(apb_en), .psel_out(psel), .penable_out(pen), .pwrite_out(pwr),
    .paddr_out(paddr), .apb_slot_out(slot), .pwdata_out(pwdata), .prdata_in(prdata),
    .pready_in(pready), .apb_wide_in(wide));
  mmd_far_model mmd_far_model_i (
    .clk_in(clk), .rst_in(rst), .ea_in(eaddr), .cs_n_in(cs_n), .oe_n_in(oe_n),
    .we_n_in(we_n), .be_n_in(be_n), .dout_in(dout), .din_out(din), .psel_in(psel),
    .pen_in(pen), .paddr_in(paddr), .slot_in(slot), .pwdata_in(pwdata), .dly_in(dly),
    .prdata_out(prdata), .pready_out(pready), .cs_seen_out(cs_seen),
    .wd_seen_out(wseen), .slot_seen_out(slot_seen), .strb_cnt_out(scnt));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    if (err_total == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  function automatic logic [6:0] exp_sel(input logic [31:0] a);
    case (a[31:28])
      4'h4: return a[27] ? 7'h02 : 7'h01;
      4'h5: return 7'h04;
      4'h7: return a[27] ? 7'h10 : 7'h08;
      4'h9: return a[27] ? 7'h00 : 7'h20;
      4'ha: return 7'h40;
      default: return 7'h00;
    endcase
  endfunction

  function automatic logic [2:0] exp_cs(input logic [31:0] a);
    int k;
    k = a[28] ? 2 : (a[27] ? 1 : 0);
    if (k < 2 && swap) k = 1 - k;
    return ~(3'h1 << k);
  endfunction

  // APB clock must follow the select, one compare per cycle
  always @(negedge clk) begin
    hready <= hrdy;
    if (apb_en === 1'b1) apb_on++;
    if (!rst) check(32'({apb_en, den}), 32'({psel, !we_n}));
  end

  task automatic wait_rdy(output int n);
    n = 0;
    while (hrdy !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 200) begin
        err_total++;
        summarize();
      end
    end
  endtask

  task automatic ahb(input logic [31:0] a, input logic wr, input logic [2:0] sz,
                     input logic [31:0] wd, output logic [31:0] rd, output int lat);
    int n;
    @(negedge clk);
    haddr = a;
    htrans = 2'b10;
    hwrite = wr;
    hsize = sz;
    wait_rdy(n);
    // Select settles after the negedge change; look at it on the taking edge
    @(posedge clk);
    sel_seen = hsel;
    @(negedge clk);
    htrans = 2'b00;
    hwdata = wd;
    wait_rdy(lat);
    rd = hrdata;
  endtask

  task automatic do_op(input logic [31:0] a, input logic wr, input logic bt);
    logic [31:0] wd, rd, r;
    logic [15:0] c0;
    logic [3:0]  h;
    logic        ext, boot, apb;
    int          lat, p0;
    r = rnd();
    wd = rnd();
    wide = r[0];
    dly = r[2:1];
    boot = (a[31:27] == 5'h00) && (bmap == BOOT_MAP_ON);
    ext = !boot && (a[31:28] == 4'h0 || a[31:27] == 5'h02);
    apb = (a[31:28] == 4'h8);
    bt = bt && ext;
    if (!bt) a[1:0] = 2'b00;
    h = a[4:1];
    c0 = scnt;
    p0 = apb_on;
    ahb(a, wr, bt ? HSIZE_BYTE : HSIZE_WORD, wd, rd, lat);
    check(32'(sel_seen), 32'(exp_sel(a)));
    check(32'(scnt - c0), ext ? (bt ? 1 : 2) * (wt + 1) : 0);
    if (boot && !wr) check(rd, a[26:3] != '0 ? 0
                                : (a[2] ? 32'h4800_0000 : 32'he51f_f004));
    if (ext) begin
      check(32'(cs_seen), 32'(exp_cs(a)));
      if (wr && bt) shadow[h][8*a[0] +: 8] = wd[8*a[1:0] +: 8];
      else if (wr) shadow[h] = wd[15:0];
      if (wr && !bt) shadow[4'(h + 1)] = wd[31:16];
      if (!wr && bt) check(32'(rd[8*a[1:0] +: 8]), 32'(shadow[h][8*a[0] +: 8]));
      if (!wr && !bt) check(rd, {shadow[4'(h + 1)], shadow[h]});
    end else if (apb) begin
      check(32'(apb_on != p0), 32'h1);
      check(32'(slot_seen), 32'(a[23:16]));
      check(32'(pwr), 32'(wr));
      if (wr) check(wseen, wide ? wd : {16'h0000, wd[15:0]});
      else check(rd, {wide ? ~a[15:0] : 16'h0, a[15:0]});
    end else begin
      check(32'(apb_on == p0), 32'h1);
      check(32'(lat), 32'h0);
      if (!boot && exp_sel(a) == '0 && !wr) check(rd, 32'h0);
    end
  endtask

  initial begin
    logic [31:0] r;
    bases = '{32'h0000_0000, 32'h0800_0000, 32'h1000_0000, 32'h8000_0000,
              32'h4800_0000, 32'h7000_0000, 32'h1800_0000, 32'ha000_0000};
    corner = '{32'h4000_0000, 32'h47ff_fffc, 32'h4800_0000, 32'h5fff_fffc, 32'h7000_0000,
               32'h7800_0000, 32'h9000_0000, 32'h9800_0000, 32'ha000_0000, 32'h1800_0000,
               32'h3fff_fffc, 32'h6000_0000, 32'hb000_0000, 32'hf000_0010};
    seed = 32'h9c3e_5436;
    rst = 1'b1;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    haddr = 32'h0;
    hwdata = 32'h0;
    swap = 1'b0;
    bmap = BOOT_MAP_ON;
    wide = 1'b0;
    dly = 2'h0;
    wt = '0;
    for (int i = 0; i < 16; i++) begin
      shadow[i] = {i[3:0], 12'h5a3};
    end
    repeat (2) @(negedge clk);
    check(32'({hrdy, cs_n, psel, oe_n, we_n, be_n}), 32'h1ef);
    check(hrdata, 32'h0);
    rst = 1'b0;
    do_op(32'h0000_0000, 1'b0, 1'b0);
    do_op(32'h0000_0004, 1'b0, 1'b0);
    do_op(32'h0000_0008, 1'b0, 1'b0);
    do_op(32'h0000_0000, 1'b1, 1'b0);
    do_op(32'h0000_0000, 1'b0, 1'b0);
    foreach (corner[i]) do_op(corner[i], 1'b0, 1'b0);
    bmap = ~BOOT_MAP_ON;
    do_op(32'h0000_0010, 1'b1, 1'b0);
    do_op(32'h0000_0011, 1'b1, 1'b1);
    do_op(32'h0000_0010, 1'b0, 1'b0);
    swap = 1'b1;
    wt = '1;
    do_op(32'h0800_0012, 1'b0, 1'b1);
    do_op(32'h1000_0000, 1'b0, 1'b0);
    do_op(32'h8001_0004, 1'b0, 1'b0);
    do_op(32'h80ff_fffc, 1'b1, 1'b0);
    for (int i = 0; i < 80; i++) begin
      r = rnd();
      swap = r[4];
      bmap = r[5];
      wt = WAIT_W'(r[7:6]);
      do_op(bases[r[10:8]] | (r & 32'h07ff_ffff), r[14], r[13]);
    end
    summarize();
  end
endmodule
`default_nettype wire
